// [include/lrx_pkg.sv]
package lrx_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_HALF_DIV = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
	localparam logic [7:0] ADDR_STATE = 8'h10;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTRL_INVERT = 0;
	localparam int CTRL_DECODE = 1;
	localparam int CTRL_RATE_LO = 2;
	localparam int CTRL_EQ = 4;
	localparam int IRQ_LOL_CHANGE = 0;
	localparam int IRQ_VIOLATION = 1;
	localparam int STATE_LOL = 0;
	localparam int STATE_EQ = 1;
	localparam int STATE_SINGLE = 2;
	localparam int STATE_HOST = 3;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [7:0] HALF_DIV_RESET = 8'h01;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

	// ****************************************************************
	// rate codes and timing
	// ****************************************************************
	localparam logic [1:0] RATE_DS3 = 2'h0;
	localparam logic [1:0] RATE_E3 = 2'h1;
	localparam logic [1:0] RATE_STS1 = 2'h2;
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOL_WINDOW_NS = 10240;
	localparam int LOL_WINDOW_CYC = LOL_WINDOW_NS / CLK_PERIOD_NS;
	localparam logic [10:0] LOL_TOLERANCE = 11'h008;
	localparam int SYNC_PINS = 8;

	typedef struct packed {
		logic pos;
		logic neg;
	} lrx_sym_t;

	typedef struct packed {
		logic eq_enable;
		logic [1:0] rate;
		logic decode_enable;
		logic clock_invert;
	} lrx_ctrl_t;

endpackage

// [rtl/lrx_receive_output.sv]
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1 - recovered clock output per channel accompanies the receive data
// R2 - by default data outputs change on recovered clock rising edge
// R3 - host mode invert control bit set moves data update to falling edge
// R4 - hardware mode invert pin high inverts clock; data on falling edge
// R5 - negative output pulses high for each negative line pulse
// R6 - positive output pulses high for each positive line pulse
// R7 - with decoder enabled, substitution patterns appear as zeros
// R8 - hardware mode equalizer pin enables equalizer; ignored in host mode
// R9 - host mode register reset pin low restores register defaults
// R10 - system supplies reference clock at the channel's line rate
// R11 - reference clock is the basis for loss-of-lock declare and clear
// R12 - channel rate is independent; transmit clock may be the reference
// R13 - rail select high gives single-rail output, low gives dual-rail
// R14 - host select high takes configuration from registers, ignores pins; the rail select pin is still read in host mode
// R15 - single-rail data on positive output, negative output held low
// R16 - B3ZS rules for DS3 and STS-1, HDB3 rules for E3
module lrx_receive_output (
	input wire logic pclk, // apb clock, 100 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic line_in_tip, // sliced positive line pulse
	input wire logic line_in_ring, // sliced negative line pulse
	input wire logic reference_clock_in, // lock reference clock
	input wire logic rx_clock_invert, // hardware mode invert pin
	input wire logic rx_equalizer_enable, // hardware mode equalizer pin
	input wire logic register_reset_n, // host mode register reset
	input wire logic rail_mode_select, // high selects single rail
	input wire logic host_mode_select, // high selects host mode
	output logic recovered_clock_out, // recovered clock
	output logic rx_positive_data, // positive or single-rail data
	output logic rx_negative_data, // negative data
	output logic rx_equalizer_active, // equalizer on
	output logic loss_of_lock, // lock alarm
	output logic irq // level interrupt
);

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	// three stages; a pin's new level counts only once stages 2 and 3 agree
	logic [lrx_pkg::SYNC_PINS-1:0] pin_raw;
	logic [lrx_pkg::SYNC_PINS-1:0] pin_s1;
	logic [lrx_pkg::SYNC_PINS-1:0] pin_s2;
	logic [lrx_pkg::SYNC_PINS-1:0] pin_s3;
	logic [lrx_pkg::SYNC_PINS-1:0] pin_f;

	assign pin_raw = {host_mode_select, rail_mode_select, register_reset_n,
		rx_equalizer_enable, rx_clock_invert, reference_clock_in,
		line_in_ring, line_in_tip};

	genvar gi;
	generate
		for (gi = 0; gi < lrx_pkg::SYNC_PINS; gi = gi + 1) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_s1[gi] <= 1'b0;
					pin_s2[gi] <= 1'b0;
					pin_s3[gi] <= 1'b0;
					pin_f[gi] <= 1'b0;
				end else begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
					if (pin_s2[gi] == pin_s3[gi]) begin
						pin_f[gi] <= pin_s3[gi];
					end
				end
			end
		end
	endgenerate

	wire tip_f = pin_f[0];
	wire ring_f = pin_f[1];
	wire ref_f = pin_f[2];
	wire inv_pin = pin_f[3];
	wire eq_pin = pin_f[4];
	wire register_reset_n_n = pin_f[5];
	wire single_rail = pin_f[6];
	wire host_mode = pin_f[7];

	// ****************************************************************
	// apb decode
	// ****************************************************************
	lrx_pkg::lrx_ctrl_t ctrl;
	logic [7:0] half_div;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic [1:0] irq_event;

	wire setup = psel && !penable;
	wire access = psel && penable && pready;
	wire sel_ctrl = paddr == lrx_pkg::ADDR_CTRL;
	wire sel_div = paddr == lrx_pkg::ADDR_HALF_DIV;
	wire sel_stat = paddr == lrx_pkg::ADDR_IRQ_STATUS;
	wire sel_mask = paddr == lrx_pkg::ADDR_IRQ_MASK;
	wire sel_state = paddr == lrx_pkg::ADDR_STATE;
	wire mapped = sel_ctrl || sel_div || sel_stat || sel_mask || sel_state;
	wire wr = access && pwrite && mapped;
	// host reset pin clears registers only while host mode is selected
	wire reg_clear = host_mode && !register_reset_n_n; // R9

	logic [31:0] rd_mux;
	assign rd_mux = sel_ctrl ? {27'h0000000, ctrl} :
		sel_div ? {24'h000000, half_div} :
		sel_stat ? {30'h0, irq_status} :
		sel_mask ? {30'h0, irq_mask} :
		sel_state ? {28'h0000000, host_mode, single_rail,
			rx_equalizer_active, loss_of_lock} : 32'h00000000;

	// one wait-free access: ready rises in the access phase's first cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			prdata <= (setup && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= lrx_pkg::CTRL_RESET;
			half_div <= lrx_pkg::HALF_DIV_RESET;
			irq_mask <= lrx_pkg::IRQ_MASK_RESET;
		end else if (reg_clear) begin
			ctrl <= lrx_pkg::CTRL_RESET; // R9
			half_div <= lrx_pkg::HALF_DIV_RESET;
			irq_mask <= lrx_pkg::IRQ_MASK_RESET;
		end else if (wr) begin
			if (sel_ctrl) begin
				ctrl <= pwdata[4:0];
			end
			if (sel_div) begin
				half_div <= pwdata[7:0];
			end
			if (sel_mask) begin
				irq_mask <= pwdata[1:0];
			end
		end
	end

	// set wins over a write-one clear landing in the same cycle
	wire [1:0] w1c = (wr && sel_stat) ? pwdata[1:0] : 2'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= 2'h0;
			irq <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~w1c) | irq_event;
			irq <= |(((irq_status & ~w1c) | irq_event) & irq_mask);
		end
	end

	// ****************************************************************
	// effective configuration
	// ****************************************************************
	// invert and equalizer read registers in host mode, discrete pins in hardware mode; decode always reads the register
	wire invert = host_mode ? ctrl.clock_invert : inv_pin; // R3 R4 R14
	wire eq_on = host_mode ? ctrl.eq_enable : eq_pin; // R8 R14
	wire decode_on = ctrl.decode_enable;
	// in hardware mode the rate pins live elsewhere; default to DS3 rules
	wire hdb3 = host_mode && (ctrl.rate == lrx_pkg::RATE_E3); // R16
	// R12: rate and divisor per instance, nothing shared between channels

	// ****************************************************************
	// recovered clock
	// ****************************************************************
	logic [7:0] half_cnt;
	logic clk_phase;
	wire half_end = half_cnt >= half_div;
	// symbol boundary on the internal rising edge of the bit clock
	wire bit_tick = half_end && !clk_phase;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_cnt <= 8'h00;
			clk_phase <= 1'b0;
			recovered_clock_out <= 1'b0;
		end else begin
			half_cnt <= half_end ? 8'h00 : half_cnt + 8'h01;
			if (half_end) begin
				clk_phase <= !clk_phase;
			end
			// inverting the pin keeps data launch on the chosen edge
			recovered_clock_out <= (half_end ? !clk_phase : clk_phase)
				^ invert; // R1 R4
		end
	end

	// ****************************************************************
	// symbol capture and zero-substitution removal
	// ****************************************************************
	// a pulse anywhere in the bit period counts as that bit's mark
	lrx_pkg::lrx_sym_t mark;
	lrx_pkg::lrx_sym_t pipe [0:3];
	logic last_pos;
	wire viol = (mark.pos && last_pos) || (mark.neg && !last_pos);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mark <= '0;
			last_pos <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				pipe[i] <= '0;
			end
		end else if (bit_tick) begin
			mark <= '0;
			if (mark.pos || mark.neg) begin
				last_pos <= mark.pos;
			end
			pipe[1] <= pipe[0];
			pipe[2] <= (decode_on && viol && !hdb3) ? '0 : pipe[1]; // R7 R16
			pipe[3] <= (decode_on && viol && hdb3) ? '0 : pipe[2]; // R7 R16
			pipe[0] <= (decode_on && viol) ? '0 : mark; // R7
		end else begin
			mark.pos <= mark.pos || tip_f; // R6
			mark.neg <= mark.neg || ring_f; // R5
		end
	end

	// ****************************************************************
	// output launch
	// ****************************************************************
	// the tail of the pipe is late enough that a B pulse is already zeroed
	// launch stays on the internal rise; the invert alone turns the pin,
	// so the framer sees data move on a falling edge and bits keep length
	wire launch = bit_tick; // R2 R3 R4
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_positive_data <= 1'b0;
			rx_negative_data <= 1'b0;
		end else if (launch) begin
			if (single_rail) begin
				rx_positive_data <= pipe[3].pos || pipe[3].neg; // R13 R15
				rx_negative_data <= 1'b0; // R15
			end else begin
				rx_positive_data <= pipe[3].pos; // R6 R13
				rx_negative_data <= pipe[3].neg; // R5
			end
		end
	end

	// ****************************************************************
	// loss of lock against the reference clock
	// ****************************************************************
	// reference above a quarter of pclk loses edges in the pin filter; feed it pre-divided if so
	logic ref_d;
	logic [10:0] ref_cnt;
	logic [10:0] sym_cnt;
	logic [15:0] win_cnt;
	wire win_end = win_cnt == 16'(lrx_pkg::LOL_WINDOW_CYC - 1);
	wire [10:0] diff = (ref_cnt > sym_cnt) ? ref_cnt - sym_cnt :
		sym_cnt - ref_cnt;
	wire lol_next = diff > lrx_pkg::LOL_TOLERANCE; // R10 R11

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_d <= 1'b0;
			ref_cnt <= 11'h000;
			sym_cnt <= 11'h000;
			win_cnt <= 16'h0000;
			loss_of_lock <= 1'b0;
			rx_equalizer_active <= 1'b0;
		end else begin
			ref_d <= ref_f;
			rx_equalizer_active <= eq_on; // R8
			win_cnt <= win_end ? 16'h0000 : win_cnt + 16'h0001;
			if (win_end) begin
				ref_cnt <= 11'h000;
				sym_cnt <= 11'h000;
				loss_of_lock <= lol_next; // R11
			end else begin
				ref_cnt <= ref_cnt + {10'h000, ref_f && !ref_d};
				sym_cnt <= sym_cnt + {10'h000, bit_tick};
			end
		end
	end

	assign irq_event[lrx_pkg::IRQ_LOL_CHANGE] =
		win_end && (lol_next != loss_of_lock);
	assign irq_event[lrx_pkg::IRQ_VIOLATION] = bit_tick && viol;

endmodule

`default_nettype wire

// [sim/lrx_receive_output_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// ********
// checker
// ********
module lrx_receive_output_checker (
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic recovered_clock_out, // bit clock
	input wire logic rx_positive_data, // data
	input wire logic rx_negative_data, // data
	input wire logic rx_clock_invert, // pin
	input wire logic rx_equalizer_enable, // pin
	input wire logic rx_equalizer_active, // state
	input wire logic rail_mode_select, // pin
	input wire logic host_mode_select // pin
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// pins cross a synchronizer, so pin tests want 8 quiet cycles
	edge_follow_a: assert property (
		$changed({rx_positive_data, rx_negative_data})
		|-> $changed(recovered_clock_out)) else $error("data off edge");
	rise_launch_a: assert property (
		$changed({rx_positive_data, rx_negative_data}) && !host_mode_select
		&& !$past(host_mode_select, 8) && !rx_clock_invert
		&& !$past(rx_clock_invert, 8) |-> $rose(recovered_clock_out))
		else $error("data not on rise");
	fall_launch_a: assert property (
		$changed({rx_positive_data, rx_negative_data}) && !host_mode_select
		&& !$past(host_mode_select, 8) && rx_clock_invert
		&& $past(rx_clock_invert, 8) |-> $fell(recovered_clock_out))
		else $error("data not on fall");
	single_neg_a: assert property (
		rail_mode_select && $past(rail_mode_select, 8) |-> !rx_negative_data)
		else $error("negative data in single rail");
	eq_pin_a: assert property (
		!host_mode_select && !$past(host_mode_select, 8)
		&& $past(rx_equalizer_enable, 8) == rx_equalizer_enable
		|-> rx_equalizer_active == rx_equalizer_enable)
		else $error("equalizer off pin");
	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("no ready");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready too long");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	bit_hold_a: assert property (
		$rose(rx_positive_data) |=> rx_positive_data [*3])
		else $error("short bit");
endmodule
bind lrx_receive_output lrx_receive_output_checker u_chk (.pclk, .presetn,
	.psel, .penable, .pready, .pslverr, .recovered_clock_out,
	.rx_positive_data, .rx_negative_data, .rx_clock_invert,
	.rx_equalizer_enable, .rx_equalizer_active, .rail_mode_select,
	.host_mode_select);
`default_nettype wire

// [sim/lrx_framer_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ********
// framer
// ********
module lrx_framer_model (
	input wire logic pclk, // clock
	input wire logic bit_clock, // recovered clock
	input wire logic invert, // launch on falling edge
	input wire lrx_pkg::lrx_sym_t sym, // data pins
	output logic got, // sample taken
	output var lrx_pkg::lrx_sym_t bits, // sample
	output logic torn // data moved on the sampling edge
);
	logic last;
	lrx_pkg::lrx_sym_t held;
	// sample on the edge opposite launch, clear of the data change
	always_ff @(posedge pclk) begin
		last <= bit_clock;
		got <= last != bit_clock && bit_clock == invert;
		bits <= sym;
		// launch on the sampling edge would show up as a change here
		held <= sym;
		torn <= held != sym;
	end
endmodule
`default_nettype wire

// [sim/test_lrx_receive_output.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
	checks++; \
	if ((a) !== (b)) begin \
		n_errors++; \
		$display("unexpected at %0t: %h not %h", $time, a, b); \
	end \
end
// ********
// bench
// ********
module test_lrx_receive_output;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, tip = 1'h0, ring = 1'h0, ref_on = 1'h1;
	logic inv_pin = 1'h0, eq_pin = 1'h0, register_reset_n_n = 1'h1, rail = 1'h0;
	logic host = 1'h0, inv_now = 1'h0, armed = 1'h0;
	logic pready, pslverr, rclk, pos, neg, eq_on, lol, irq, got, torn;
	logic [1:0] refdiv = 2'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'h00E5;
	logic [32:0] r_exp;
	logic [32:0] rq[$];
	lrx_pkg::lrx_sym_t bits, s_exp;
	lrx_pkg::lrx_sym_t sq[$];
	int n_errors = 0, checks = 0;

	lrx_receive_output dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .line_in_tip(tip),
		.line_in_ring(ring), .reference_clock_in(refdiv[1]),
		.rx_clock_invert(inv_pin), .rx_equalizer_enable(eq_pin),
		.register_reset_n(register_reset_n_n), .rail_mode_select(rail),
		.host_mode_select(host), .recovered_clock_out(rclk),
		.rx_positive_data(pos), .rx_negative_data(neg),
		.rx_equalizer_active(eq_on), .loss_of_lock(lol), .irq);
	lrx_framer_model frm (.pclk, .bit_clock(rclk), .invert(inv_now),
		.sym({pos, neg}), .got, .bits, .torn);

	initial begin
		forever #5 pclk = ~pclk;
	end
	// reference at the bit rate: one rising edge per 4-cycle bit
	always @(posedge pclk) if (ref_on) refdiv <= refdiv + 2'h1;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic results();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic fail_out();
		n_errors++;
		results();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic e);
		int k;
		if (!w) rq.push_back({e, d});
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
		if (k >= 20) fail_out();
	endtask
	// two cycles survive the pin filter yet never mark two bit periods
	task automatic send(input lrx_pkg::lrx_sym_t s, input lrx_pkg::lrx_sym_t e);
		int k;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (got !== 1'h1 && k < 40);
		if (k >= 40) fail_out();
		tip <= s.pos;
		ring <= s.neg;
		sq.push_back(e);
		@(posedge pclk);
		@(posedge pclk);
		tip <= 1'h0;
		ring <= 1'h0;
	endtask
	task automatic drain();
		int k;
		k = 0;
		while (sq.size() > 0 && k < 200) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 200) fail_out();
	endtask
	task automatic play(input logic [15:0] l, input logic [15:0] e, int n);
		for (int i = 0; i < n; i++) send(l[15-2*i -: 2], e[15-2*i -: 2]);
		drain();
	endtask
	// streams open with a pulse and end on a negative one
	task automatic stream_random();
		lrx_pkg::lrx_sym_t s;
		send(2'h2, 2'h2);
		for (int i = 0; i < 12; i++) begin
			seed = xs(seed);
			s = {seed[0] & ~seed[1], seed[1] & ~seed[0]};
			send(s, s);
		end
		send(2'h1, 2'h1);
		drain();
	endtask

	always @(posedge pclk) begin
		if (got === 1'h1 && sq.size() > 0 && (armed || bits != 2'h0)) begin
			armed = 1'h1;
			s_exp = sq.pop_front();
			`CHK(bits, s_exp)
			`CHK(torn, 1'h0)
			armed = sq.size() > 0;
		end else if (got === 1'h1 && sq.size() == 0) `CHK(bits, 2'h0)
		if (psel && penable && pready === 1'h1 && !pwrite) begin
			r_exp = rq.pop_front();
			`CHK({pslverr, prdata}, r_exp)
		end
	end

	initial begin
		tick(10);
		presetn <= 1'h1;
		tick(10);
		apb(0, lrx_pkg::ADDR_CTRL, 32'(lrx_pkg::CTRL_RESET), 0);
		apb(0, lrx_pkg::ADDR_HALF_DIV, 32'(lrx_pkg::HALF_DIV_RESET), 0);
		apb(0, lrx_pkg::ADDR_IRQ_MASK, 32'(lrx_pkg::IRQ_MASK_RESET), 0);
		apb(0, 8'h14, 32'h0, 1);
		stream_random();
		inv_pin <= 1'h1;
		inv_now <= 1'h1;
		tick(20);
		stream_random();
		eq_pin <= 1'h1;
		tick(20);
		`CHK(eq_on, 1'h1)
		host <= 1'h1;
		rail <= 1'h1;
		inv_pin <= 1'h0;
		inv_now <= 1'h0;
		tick(20);
		`CHK(eq_on, 1'h0)
		for (int i = 0; i < 2; i++) begin
			apb(1, lrx_pkg::ADDR_CTRL, {28'h0, i ? lrx_pkg::RATE_STS1 :
				lrx_pkg::RATE_DS3, 2'h2}, 0);
			tick(20);
			play(16'h9890, 16'hA020, 6);
		end
		`CHK(irq, 1'h0)
		apb(1, lrx_pkg::ADDR_IRQ_MASK, 32'h2, 0);
		tick(4);
		`CHK(irq, 1'h1)
		apb(1, lrx_pkg::ADDR_IRQ_STATUS, 32'h2, 0);
		tick(4);
		`CHK(irq, 1'h0)
		rail <= 1'h0;
		apb(1, lrx_pkg::ADDR_CTRL, {28'h0, lrx_pkg::RATE_E3, 2'h3}, 0);
		inv_now <= 1'h1;
		tick(20);
		play(16'h9824, 16'h9004, 7);
		register_reset_n_n <= 1'h0;
		inv_now <= 1'h0;
		tick(10);
		register_reset_n_n <= 1'h1;
		tick(10);
		apb(0, lrx_pkg::ADDR_CTRL, 32'h0, 0);
		`CHK(lol, 1'h0)
		ref_on <= 1'h0;
		rail <= 1'h1;
		tick(2200);
		`CHK(lol, 1'h1)
		ref_on <= 1'h1;
		tick(2200);
		`CHK(lol, 1'h0)
		apb(0, lrx_pkg::ADDR_STATE, 32'hC, 0);
		results();
	end
	initial begin
		tick(60000);
		fail_out();
	end
endmodule
`default_nettype wire
